// ---- common/adc_ctrl_pkg.sv ----
// Shared constants and carrier types for the converter control port
package adc_ctrl_pkg;

    // ========================================
    // Interface modes
    // ========================================
    localparam logic [1:0] MODE_SERIAL = 2'h3;

    // ========================================
    // Timing
    // ========================================
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_TIME_NS = 1500;
    localparam int CAL_TIME_NS = 4000;
    // Least times round up to whole cycles
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_BITS = 12;

    // ========================================
    // Result and configuration word
    // ========================================
    localparam int RESULT_BITS = 18;
    localparam int SHARED_LO_BIT = 16;
    localparam int SHARED_HI_BIT = 17;
    localparam int CFG_BITS = 2;
    localparam int CFG_TEN_POS = 1;
    localparam int CFG_BIP_POS = 0;
    localparam logic [1:0] CFG_RESET = 2'h0;

    // ========================================
    // Pin synchroniser lanes
    // ========================================
    localparam int SYNC_LANES = 11;

    typedef struct packed {
        logic range_10v;
        logic signed_range;
    } range_t;

    typedef struct packed {
        logic ref_enable;
        logic buffer_enable;
        logic ext_ref_buffered;
    } ref_state_t;

    typedef enum {
        ST_IDLE,
        ST_HELD,
        ST_CAL,
        ST_CONV
    } conv_state_t;

endpackage : adc_ctrl_pkg

// ---- hdl/cfg_shift_port.sv ----
// Serial configuration shifter fed by synchronised port pins
`timescale 1ns/1ps
`default_nettype none
module cfg_shift_port #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic accept,
    input wire logic port_clock,
    input wire logic port_data,
    input wire logic port_enable,
    input wire logic edge_invert,
    output logic [WIDTH-1:0] cfg_word
);

    // ========================================
    // Edge detection
    // ========================================
    logic clock_prev;
    logic enable_prev;
    logic [WIDTH-1:0] shift;
    logic [7:0] bit_count;
    wire live = accept & port_enable;
    wire rise = port_clock & ~clock_prev;
    wire fall = ~port_clock & clock_prev;
    // Host updates on one edge, so sample on the other
    wire sample = live & (edge_invert ? rise : fall);
    wire frame_end = accept & enable_prev & ~port_enable;
    wire full = bit_count >= 8'(WIDTH);
    wire [WIDTH-1:0] next_shift = {shift[WIDTH-2:0], port_data};

    // ========================================
    // Shift and commit
    // ========================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_prev <= 1'b0;
            enable_prev <= 1'b0;
            shift <= '0;
            bit_count <= 8'h00;
            cfg_word <= adc_ctrl_pkg::CFG_RESET;
        end else if (ce) begin
            clock_prev <= port_clock;
            enable_prev <= port_enable;
            if (!live) begin
                bit_count <= 8'h00;
            end else if (sample) begin
                shift <= next_shift;
                bit_count <= full ? bit_count : bit_count + 8'h01;
            end
            // Short frames are dropped, stored word kept
            if (frame_end && full) begin
                cfg_word <= shift;
            end
        end
    end

endmodule : cfg_shift_port
`default_nettype wire

// ---- hdl/adc_conversion_control_port.sv ----
// Digital control side of a sampling converter
// How it works
// - Modes 0 to 2: shared pins drive parallel result bits 16 and 17.
// - Serial mode: config clock samples config data, edge picked by invert pin.
// - Serial mode: config port works only while its enable is asserted.
// - Busy rises at conversion start, falls once result is latched.
// - Parallel modes: ten-volt pin selects the 10 V range.
// - Serial mode, pin select high: ten-volt pin high selects 10 V.
// - Serial mode, pin select low: range comes from config port only.
// - Parallel modes: bipolar pin selects the bipolar range.
// - Serial mode, pin select high: bipolar pin high selects bipolar.
// - Output bus enabled only while chip select and read are both low.
// - Serial slave clock edges count only while chip select is low.
// - Reset pin high holds the device and aborts any conversion.
// - Reset falling edge starts calibration, busy high until it ends.
// - Power-down finishes current conversion, then refuses new starts.
// - Falling edge of conversion start holds the sample and converts.
// - Internal reference on only when both reference power-downs are low.
// - Buffer enabled while buffer power-down low, off when high.
// - Buffer low, reference high: external reference through internal buffer.
// - Config data accepted only while pin select is low.
// - Invert low: data updates on rising edge; high: on falling edge.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_port #(
    parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES,
    parameter int CAL_CYCLES = adc_ctrl_pkg::CAL_CYCLES
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic CONVERSION_START_N_IN,
    input wire logic DEVICE_RESET_IN,
    input wire logic POWER_DOWN_REQUEST_IN,
    input wire logic CS_N_IN,
    input wire logic RD_N_IN,
    input wire logic RANGE_10V_SELECT_IN,
    input wire logic SIGNED_RANGE_SELECT_IN,
    input wire logic PIN_OR_SERIAL_CONFIG_SELECT_IN,
    input wire logic CLOCK_EDGE_INVERT_IN,
    input wire logic REF_POWER_DOWN_IN,
    input wire logic REF_BUFFER_POWER_DOWN_IN,
    input wire logic SERIAL_DATA_CLOCK_IN,
    input wire logic [17:0] CORE_RESULT_IN,
    input wire logic SHARED_PIN_16_IN,
    input wire logic SHARED_PIN_17_IN,
    input wire logic CFG_PORT_DATA_IN,
    output logic SHARED_PIN_16_OUT,
    output logic SHARED_PIN_16_OE_OUT,
    output logic SHARED_PIN_17_OUT,
    output logic SHARED_PIN_17_OE_OUT,
    output logic BUSY_OUT,
    output logic SAMPLE_HOLD_OUT,
    output logic CALIBRATING_OUT,
    output logic POWERED_DOWN_OUT,
    output logic OUTPUT_BUS_ENABLE_OUT,
    output logic SERIAL_CLOCK_EDGE_OUT,
    output logic [17:0] RESULT_OUT,
    output logic RANGE_10V_OUT,
    output logic SIGNED_RANGE_OUT,
    output logic REF_ENABLE_OUT,
    output logic REF_BUFFER_ENABLE_OUT,
    output logic EXT_REF_BUFFERED_OUT
);

    // ========================================
    // Pin synchronisers
    // ========================================
    localparam int N = adc_ctrl_pkg::SYNC_LANES;

    wire [N-1:0] raw_pins = {
        CONVERSION_START_N_IN,
        DEVICE_RESET_IN,
        POWER_DOWN_REQUEST_IN,
        CS_N_IN,
        RD_N_IN,
        RANGE_10V_SELECT_IN,
        SIGNED_RANGE_SELECT_IN,
        PIN_OR_SERIAL_CONFIG_SELECT_IN,
        CLOCK_EDGE_INVERT_IN,
        SERIAL_DATA_CLOCK_IN,
        SHARED_PIN_16_IN
    };

    logic [N-1:0] sync_stage1;
    logic [N-1:0] sync_pins;
    logic pin17_stage1;
    logic pin17_sync;
    logic [1:0] mode_stage1;
    logic [1:0] mode_sync;

    // Only the second stage is ever read downstream
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sync_stage1 <= 11'h000;
            sync_pins <= 11'h000;
        end else if (CE_IN) begin
            sync_stage1 <= raw_pins;
            sync_pins <= sync_stage1;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin17_stage1 <= 1'b0;
            pin17_sync <= 1'b0;
            mode_stage1 <= 2'h0;
            mode_sync <= 2'h0;
        end else if (CE_IN) begin
            pin17_stage1 <= SHARED_PIN_17_IN;
            pin17_sync <= pin17_stage1;
            mode_stage1 <= MODE_IN;
            mode_sync <= mode_stage1;
        end
    end

    wire conversion_start_n_n = sync_pins[10];
    wire dev_reset = sync_pins[9];
    wire pd_req = sync_pins[8];
    wire cs_n = sync_pins[7];
    wire rd_n = sync_pins[6];
    wire ten_pin = sync_pins[5];
    wire bip_pin = sync_pins[4];
    wire hw_select = sync_pins[3];
    wire edge_inv = sync_pins[2];
    wire data_clk = sync_pins[1];
    wire pin16 = sync_pins[0];

    // ========================================
    // Mode decode
    // ========================================
    wire serial_mode = mode_sync == adc_ctrl_pkg::MODE_SERIAL;
    wire pin_config = ~serial_mode | hw_select;
    // Shared pins carry port clock and enable
    wire cfg_port_clock = pin16;
    wire cfg_port_enable = pin17_sync;
    logic cfg_data_stage1;
    logic cfg_data_sync;
    // Config data pin crosses domains like the rest
    wire cfg_port_data = cfg_data_sync;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cfg_data_stage1 <= 1'b0;
            cfg_data_sync <= 1'b0;
        end else if (CE_IN) begin
            cfg_data_stage1 <= CFG_PORT_DATA_IN;
            cfg_data_sync <= cfg_data_stage1;
        end
    end

    // ========================================
    // Serial configuration port
    // ========================================
    logic [adc_ctrl_pkg::CFG_BITS-1:0] cfg_word;

    wire cfg_accept = serial_mode & ~hw_select & ~dev_reset;

    cfg_shift_port #(
        .WIDTH(adc_ctrl_pkg::CFG_BITS)
    ) u_cfg_port (
        .clk(MCLK_IN),
        .rst(RST_IN),
        .ce(CE_IN),
        .accept(cfg_accept),
        .port_clock(cfg_port_clock),
        .port_data(cfg_port_data),
        .port_enable(cfg_port_enable),
        .edge_invert(edge_inv),
        .cfg_word(cfg_word)
    );

    // ========================================
    // Range selection
    // ========================================
    adc_ctrl_pkg::range_t pin_range;
    adc_ctrl_pkg::range_t soft_range;
    adc_ctrl_pkg::range_t next_range;
    adc_ctrl_pkg::range_t range;

    assign pin_range.range_10v = ten_pin;
    assign pin_range.signed_range = bip_pin;
    assign soft_range.range_10v = cfg_word[adc_ctrl_pkg::CFG_TEN_POS];
    assign soft_range.signed_range = cfg_word[adc_ctrl_pkg::CFG_BIP_POS];
    assign next_range = pin_config ? pin_range : soft_range;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            range <= '0;
        end else if (CE_IN) begin
            range <= next_range;
        end
    end

    assign RANGE_10V_OUT = range.range_10v;
    assign SIGNED_RANGE_OUT = range.signed_range;

    // ========================================
    // Conversion sequencer
    // ========================================
    adc_ctrl_pkg::conv_state_t state;
    adc_ctrl_pkg::conv_state_t next_state;
    logic [adc_ctrl_pkg::TIMER_BITS-1:0] timer;
    logic conversion_start_n_prev;
    logic reset_prev;
    logic [17:0] result;

    wire in_reset = dev_reset;
    wire start_edge = conversion_start_n_prev & ~conversion_start_n_n;
    wire cal_edge = reset_prev & ~dev_reset;
    wire timer_done = timer == '0;
    wire start_ok = start_edge & ~pd_req;
    wire conv_end = state == adc_ctrl_pkg::ST_CONV && timer_done;

    always_comb begin
        next_state = state;
        case (state)
            adc_ctrl_pkg::ST_HELD: begin
                if (cal_edge) begin
                    next_state = adc_ctrl_pkg::ST_CAL;
                end
            end
            adc_ctrl_pkg::ST_CAL: begin
                if (timer_done) begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (timer_done) begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end
            end
            adc_ctrl_pkg::ST_IDLE: begin
                if (start_ok) begin
                    next_state = adc_ctrl_pkg::ST_CONV;
                end
            end
            default: begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
        if (in_reset) begin
            next_state = adc_ctrl_pkg::ST_HELD;
        end
    end

    wire load_conv = next_state == adc_ctrl_pkg::ST_CONV && state != adc_ctrl_pkg::ST_CONV;
    wire load_cal = next_state == adc_ctrl_pkg::ST_CAL && state != adc_ctrl_pkg::ST_CAL;
    wire [adc_ctrl_pkg::TIMER_BITS-1:0] conv_load = adc_ctrl_pkg::TIMER_BITS'(CONV_CYCLES - 1);
    wire [adc_ctrl_pkg::TIMER_BITS-1:0] cal_load = adc_ctrl_pkg::TIMER_BITS'(CAL_CYCLES - 1);

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= adc_ctrl_pkg::ST_IDLE;
            timer <= '0;
            // Low so the zeroed sync lane gives no false start
            conversion_start_n_prev <= 1'b0;
            reset_prev <= 1'b0;
        end else if (CE_IN) begin
            state <= next_state;
            conversion_start_n_prev <= conversion_start_n_n;
            reset_prev <= dev_reset;
            if (load_conv) begin
                timer <= conv_load;
            end else if (load_cal) begin
                timer <= cal_load;
            end else if (!timer_done) begin
                timer <= timer - 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            result <= 18'h00000;
        end else if (CE_IN && conv_end && !in_reset) begin
            result <= CORE_RESULT_IN;
        end
    end

    assign BUSY_OUT = state == adc_ctrl_pkg::ST_CONV || state == adc_ctrl_pkg::ST_CAL;
    assign SAMPLE_HOLD_OUT = state == adc_ctrl_pkg::ST_CONV;
    assign CALIBRATING_OUT = state == adc_ctrl_pkg::ST_CAL;
    assign POWERED_DOWN_OUT = pd_req;
    assign RESULT_OUT = result;

    // ========================================
    // Read enable and shared pins
    // ========================================
    // both strobes low
    wire bus_enable = ~cs_n & ~rd_n;
    assign OUTPUT_BUS_ENABLE_OUT = bus_enable;

    wire drive_shared = ~serial_mode & bus_enable;
    assign SHARED_PIN_16_OUT = result[adc_ctrl_pkg::SHARED_LO_BIT];
    assign SHARED_PIN_17_OUT = result[adc_ctrl_pkg::SHARED_HI_BIT];
    assign SHARED_PIN_16_OE_OUT = drive_shared;
    assign SHARED_PIN_17_OE_OUT = drive_shared;

    // ========================================
    // Slave data clock gating
    // ========================================
    logic data_clk_prev;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            data_clk_prev <= 1'b0;
        end else if (CE_IN) begin
            data_clk_prev <= data_clk;
        end
    end

    wire data_clk_edge = edge_inv ? (data_clk_prev & ~data_clk) : (data_clk & ~data_clk_prev);
    assign SERIAL_CLOCK_EDGE_OUT = serial_mode & ~cs_n & data_clk_edge;

    // ========================================
    // Reference control
    // ========================================
    adc_ctrl_pkg::ref_state_t ref_state;

    assign ref_state.ref_enable = ~REF_POWER_DOWN_IN & ~REF_BUFFER_POWER_DOWN_IN;
    assign ref_state.buffer_enable = ~REF_BUFFER_POWER_DOWN_IN;
    assign ref_state.ext_ref_buffered = REF_POWER_DOWN_IN & ~REF_BUFFER_POWER_DOWN_IN;

    // Static straps, still registered for clean outputs
    adc_ctrl_pkg::ref_state_t ref_reg;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ref_reg <= '0;
        end else if (CE_IN) begin
            ref_reg <= ref_state;
        end
    end

    assign REF_ENABLE_OUT = ref_reg.ref_enable;
    assign REF_BUFFER_ENABLE_OUT = ref_reg.buffer_enable;
    assign EXT_REF_BUFFERED_OUT = ref_reg.ext_ref_buffered;

endmodule : adc_conversion_control_port
`default_nettype wire

// ---- hdl/unused_placeholder_note.sv ----
// Intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verif/adc_port_assertions.sv ----
// Port checker for the converter control port
`timescale 1ns/1ps
`default_nettype none
module adc_port_checker #(
    parameter int CONV_CYCLES = 4,
    parameter int CAL_CYCLES = 4
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic [1:0] MODE_IN,
    input wire logic DEVICE_RESET_IN,
    input wire logic POWER_DOWN_REQUEST_IN,
    input wire logic CS_N_IN,
    input wire logic RD_N_IN,
    input wire logic RANGE_10V_SELECT_IN,
    input wire logic PIN_OR_SERIAL_CONFIG_SELECT_IN,
    input wire logic REF_POWER_DOWN_IN,
    input wire logic REF_BUFFER_POWER_DOWN_IN,
    input wire logic SHARED_PIN_16_OE_OUT,
    input wire logic BUSY_OUT,
    input wire logic SAMPLE_HOLD_OUT,
    input wire logic CALIBRATING_OUT,
    input wire logic OUTPUT_BUS_ENABLE_OUT,
    input wire logic SERIAL_CLOCK_EDGE_OUT,
    input wire logic [17:0] RESULT_OUT,
    input wire logic RANGE_10V_OUT,
    input wire logic REF_ENABLE_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    // ====
    // Run-length counters
    // ====
    logic [11:0] hold_cnt;
    logic [11:0] cal_cnt;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hold_cnt <= 12'h0;
            cal_cnt <= 12'h0;
        end else begin
            hold_cnt <= SAMPLE_HOLD_OUT ? hold_cnt + 12'h1 : 12'h0;
            cal_cnt <= CALIBRATING_OUT ? cal_cnt + 12'h1 : 12'h0;
        end
    end
    // ====
    // Properties
    // ====
    conv_length_a: assert property ($fell(SAMPLE_HOLD_OUT) && !DEVICE_RESET_IN
        && !$past(DEVICE_RESET_IN, 3) |-> hold_cnt == CONV_CYCLES) else $error("bad conv length");
    cal_length_a: assert property ($fell(CALIBRATING_OUT) && !DEVICE_RESET_IN
        |-> cal_cnt == CAL_CYCLES) else $error("bad calibration length");
    busy_source_a: assert property (BUSY_OUT == (SAMPLE_HOLD_OUT || CALIBRATING_OUT))
        else $error("busy not conversion or calibration");
    held_idle_a: assert property (DEVICE_RESET_IN [*4] |-> !BUSY_OUT)
        else $error("busy while held");
    result_moment_a: assert property (!$stable(RESULT_OUT) |-> $fell(SAMPLE_HOLD_OUT))
        else $error("result moved outside busy fall");
    pd_refuse_a: assert property (POWER_DOWN_REQUEST_IN [*5] |-> !$rose(SAMPLE_HOLD_OUT))
        else $error("start taken while powered down");
    bus_enable_a: assert property (($stable(CS_N_IN) && $stable(RD_N_IN)) [*4]
        |-> OUTPUT_BUS_ENABLE_OUT == (!CS_N_IN && !RD_N_IN)) else $error("bus enable wrong");
    shared_oe_a: assert property ((MODE_IN == adc_ctrl_pkg::MODE_SERIAL) [*4]
        |-> !SHARED_PIN_16_OE_OUT) else $error("shared pin driven in serial mode");
    slave_gate_a: assert property (CS_N_IN [*4] |-> !SERIAL_CLOCK_EDGE_OUT)
        else $error("clock edge counted without select");
    range_pin_a: assert property (((MODE_IN != 2'h3 || PIN_OR_SERIAL_CONFIG_SELECT_IN)
        && $stable({MODE_IN, PIN_OR_SERIAL_CONFIG_SELECT_IN, RANGE_10V_SELECT_IN})) [*5]
        |-> RANGE_10V_OUT == RANGE_10V_SELECT_IN) else $error("range not from pin");
    ref_enable_a: assert property (REF_ENABLE_OUT
        |-> !REF_POWER_DOWN_IN && !REF_BUFFER_POWER_DOWN_IN) else $error("reference on wrongly");
    conv_c: cover property ($fell(SAMPLE_HOLD_OUT));
    cal_c: cover property ($fell(CALIBRATING_OUT));
    edge_c: cover property (SERIAL_CLOCK_EDGE_OUT);
endmodule : adc_port_checker
bind adc_conversion_control_port adc_port_checker #(
    .CONV_CYCLES(CONV_CYCLES), .CAL_CYCLES(CAL_CYCLES)) port_chk (
    .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .MODE_IN(MODE_IN), .DEVICE_RESET_IN(DEVICE_RESET_IN),
    .POWER_DOWN_REQUEST_IN(POWER_DOWN_REQUEST_IN), .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN),
    .RANGE_10V_SELECT_IN(RANGE_10V_SELECT_IN),
    .PIN_OR_SERIAL_CONFIG_SELECT_IN(PIN_OR_SERIAL_CONFIG_SELECT_IN),
    .REF_POWER_DOWN_IN(REF_POWER_DOWN_IN), .REF_BUFFER_POWER_DOWN_IN(REF_BUFFER_POWER_DOWN_IN),
    .SHARED_PIN_16_OE_OUT(SHARED_PIN_16_OE_OUT), .BUSY_OUT(BUSY_OUT),
    .SAMPLE_HOLD_OUT(SAMPLE_HOLD_OUT), .CALIBRATING_OUT(CALIBRATING_OUT),
    .OUTPUT_BUS_ENABLE_OUT(OUTPUT_BUS_ENABLE_OUT), .SERIAL_CLOCK_EDGE_OUT(SERIAL_CLOCK_EDGE_OUT),
    .RESULT_OUT(RESULT_OUT), .RANGE_10V_OUT(RANGE_10V_OUT), .REF_ENABLE_OUT(REF_ENABLE_OUT));
`default_nettype wire

// ---- verif/host_model.sv ----
// Host model driving conversion start and the slave data clock
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic start_n,
    output logic data_clock
);
    initial begin
        start_n = 1'b1;
        data_clock = 1'b0;
    end
    // ====
    // Requests
    // ====
    // falling start edge
    // High first so the edge detector sees a fresh fall
    task automatic start_conv();
        repeat (2) @(posedge clk);
        start_n <= 1'b0;
        repeat (4) @(posedge clk);
        start_n <= 1'b1;
    endtask : start_conv
    // framed data clock
    // Stands low between frames; offset keeps it off the bench clock edges
    task automatic clock_frame(input int edges);
        #13;
        repeat (edges) begin
            #160 data_clock = 1'b1;
            #160 data_clock = 1'b0;
        end
    endtask : clock_frame
endmodule : host_model
`default_nettype wire

// ---- verif/adc_conversion_control_port_tb.sv ----
// Self-checking bench for the converter control port
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_port_tb;
    localparam int CONV = 12;
    localparam int CAL = 8;
    logic mclk, rst, dev_rst, pd, cs_n, rd_n, r10, sgn, pin_sel, inv, ref_power_down, ref_buffer_power_down;
    logic [1:0] mode;
    logic [17:0] core, result, res_out;
    logic [31:0] seed;
    wire logic conv_n, dclk;
    logic sp16, sp16_oe, busy, cal, pwr, bus_en, edge_p, rng10, rngs, ref_en, buf_en, ext_ref;
    int bad_count, compares, edges;
    int exp_q[$];
    host_model host (.clk(mclk), .start_n(conv_n), .data_clock(dclk));
    adc_conversion_control_port #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL)) uut (
        .MCLK_IN(mclk), .RST_IN(rst), .CE_IN(1'b1), .MODE_IN(mode),
        .CONVERSION_START_N_IN(conv_n), .DEVICE_RESET_IN(dev_rst),
        .POWER_DOWN_REQUEST_IN(pd), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
        .RANGE_10V_SELECT_IN(r10), .SIGNED_RANGE_SELECT_IN(sgn),
        .PIN_OR_SERIAL_CONFIG_SELECT_IN(pin_sel), .CLOCK_EDGE_INVERT_IN(inv),
        .REF_POWER_DOWN_IN(ref_power_down), .REF_BUFFER_POWER_DOWN_IN(ref_buffer_power_down),
        .SERIAL_DATA_CLOCK_IN(dclk), .CORE_RESULT_IN(core), .SHARED_PIN_16_IN(1'b0),
        .SHARED_PIN_17_IN(1'b0), .CFG_PORT_DATA_IN(1'b0),
        .SHARED_PIN_16_OUT(sp16), .SHARED_PIN_16_OE_OUT(sp16_oe),
        .SHARED_PIN_17_OUT(), .SHARED_PIN_17_OE_OUT(), .BUSY_OUT(busy), .SAMPLE_HOLD_OUT(),
        .CALIBRATING_OUT(cal), .POWERED_DOWN_OUT(pwr), .OUTPUT_BUS_ENABLE_OUT(bus_en),
        .SERIAL_CLOCK_EDGE_OUT(edge_p), .RESULT_OUT(res_out), .RANGE_10V_OUT(rng10),
        .SIGNED_RANGE_OUT(rngs), .REF_ENABLE_OUT(ref_en), .REF_BUFFER_ENABLE_OUT(buf_en),
        .EXT_REF_BUFFERED_OUT(ext_ref));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) if (edge_p === 1'b1) edges <= edges + 1;
    // ====
    // Helpers
    // ====
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [17:0] got, input logic [17:0] want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 200 && busy !== lvl; i++) @(negedge mclk);
        chk(18'(busy), 18'(lvl));
    endtask : wait_busy
    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done
    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // Kind 1 adds a start while busy, kind 2 a power-down request mid-conversion
    task automatic convert(input int kind);
        tick(1);
        seed = lfsr(seed);
        core <= seed[17:0];
        exp_q.push_back(int'(seed[17:0]));
        host.start_conv();
        wait_busy(1'b1);
        if (kind == 1) host.start_conv();
        if (kind == 2) begin
            tick(1);
            pd <= 1'b1;
        end
        wait_busy(1'b0);
        result = 18'(exp_q.pop_front());
        chk(res_out, result);
        chk(18'(sp16), 18'(result[16]));
    endtask : convert
    // ====
    // Scenarios
    // ====
    initial begin : watchdog
        #400000;
        bad_count++;
        $display("BAD %0t run did not finish", $time);
        results();
    end
    initial begin : main
        {rst, dev_rst, pd, cs_n, rd_n, r10, sgn, pin_sel, inv, ref_power_down, ref_buffer_power_down} = 11'h4c0;
        {mode, core, seed, bad_count, compares, edges} = {2'h0, 18'h0, 32'h35ab, 96'h0};
        // Straps are registered every clock; each pair still gets its own reset
        for (int i = 0; i < 4; i++) begin
            tick(1);
            rst <= 1'b1;
            {ref_power_down, ref_buffer_power_down} <= 2'(i);
            tick(8);
            rst <= 1'b0;
            tick(4);
            @(negedge mclk);
            chk(18'(ref_en), 18'(i == 0));
            chk(18'(buf_en), 18'(i % 2 == 0));
            chk(18'(ext_ref), 18'(i == 2));
        end
        done("reference");
        for (int i = 0; i < 8; i++) begin
            tick(1);
            mode <= (i > 3) ? 2'h3 : 2'h0;
            {cs_n, rd_n} <= 2'(i);
            tick(4);
            @(negedge mclk);
            chk(18'(bus_en), 18'(i % 4 == 0));
            chk(18'(sp16_oe), 18'(i == 0));
        end
        done("bus");
        // No frame was sent, so serial selection shows the reset word
        for (int i = 0; i < 12; i++) begin
            tick(1);
            mode <= (i < 4) ? 2'h0 : 2'h3;
            pin_sel <= (i < 8);
            {r10, sgn} <= 2'(i);
            tick(5);
            @(negedge mclk);
            chk(18'({rng10, rngs}), (i < 8) ? 18'(i % 4) : 18'h0);
        end
        done("range");
        tick(1);
        {mode, cs_n, rd_n} <= 4'h0;
        for (int i = 0; i < 3; i++) convert(i);
        host.start_conv();
        tick(8);
        @(negedge mclk);
        chk(18'(busy), 18'h0);
        chk(18'(pwr), 18'h1);
        tick(1);
        pd <= 1'b0;
        convert(0);
        done("convert");
        tick(1);
        core <= ~result;
        host.start_conv();
        wait_busy(1'b1);
        tick(1);
        dev_rst <= 1'b1;
        tick(6);
        @(negedge mclk);
        chk(18'(busy), 18'h0);
        chk(res_out, result);
        tick(1);
        dev_rst <= 1'b0;
        wait_busy(1'b1);
        chk(18'(cal), 18'h1);
        wait_busy(1'b0);
        done("device reset");
        for (int i = 0; i < 3; i++) begin
            tick(1);
            mode <= 2'h3;
            inv <= i[0];
            cs_n <= (i == 2);
            tick(4);
            edges = 0;
            host.clock_frame(4);
            tick(6);
            @(negedge mclk);
            chk(18'(edges), (i == 2) ? 18'h0 : 18'h4);
        end
        done("serial clock");
        results();
    end
endmodule : adc_conversion_control_port_tb
`default_nettype wire
